/* rtl/rx_slot_map.sv */
// receive slot mapping for channels 2 to 4 of the second serial port
// assumes apb on pclk; bclk, fsync and both data pins come from the far end
// and are launched on bclk, so they are sampled directly in the bclk domain
`timescale 1ns/100ps

// Functional notes
// - channel 2 enable bit 5: clear disables, set delivers to dac channel 2
// - channel 3 enable bit 5: clear disables, set routes to dac channel 3
// - channel 4 enable bit 5: clear disables, set routes to dac channel 4
// - channel 2 register resets to slot 1, disabled
// - channel 4 register resets to slot 3, reads 0x03
// - channel 3 register resets to 0x02, disabled, slot 2
// - bits 7-6 read zero; host writes zeros there
// - per channel select takes data from primary pin (0) or second pin (1)
// - slot 0 msb shifted by 0 to 31 bit clocks from standard framing
module rx_slot_map
  import rx_slot_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial link
  input  wire logic        bclk,
  input  wire logic        fsync,
  input  wire logic        din,
  input  wire logic        second_serial_input,
  // dac channel outputs
  output logic      [31:0] dac_data_ch2,
  output logic      [31:0] dac_data_ch3,
  output logic      [31:0] dac_data_ch4,
  output logic      [2:0]  dac_valid
);

  // register file, pclk domain
  logic [5:0]  ch2_r;
  logic [5:0]  ch3_r;
  logic [5:0]  ch4_r;
  logic [4:0]  offset_r;
  logic [2:0]  sel_r;
  logic [3:0]  fmt_r;
  logic [7:0]  frames_r;

  wire         setup    = psel & ~penable;
  wire         wr_go    = psel & penable & pready & pwrite;
  wire         hit_ch2  = paddr == ADDR_CH2;
  wire         hit_ch3  = paddr == ADDR_CH3;
  wire         hit_ch4  = paddr == ADDR_CH4;
  wire         hit_off  = paddr == ADDR_OFFSET;
  wire         hit_sel  = paddr == ADDR_SEL;
  wire         hit_fmt  = paddr == ADDR_FMT;
  wire         hit_stat = paddr == ADDR_STAT;
  wire         mapped   = hit_ch2 | hit_ch3 | hit_ch4 | hit_off | hit_sel
                        | hit_fmt | hit_stat;

  // reserved bits 7-6 of the channel registers always read zero
  wire  [31:0] rd_val   = hit_ch2 ? {26'h0, ch2_r} :
                          hit_ch3 ? {26'h0, ch3_r} :
                          hit_ch4 ? {26'h0, ch4_r} :
                          hit_off ? {27'h0, offset_r} :
                          hit_sel ? {28'h0, sel_r, 1'b0} :
                          hit_fmt ? {28'h0, fmt_r} :
                          hit_stat ? {24'h0, frames_r} :
                          32'h0000_0000;

  // answer is prepared in the setup cycle so every access has no wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ch2_r    <= CH2_RST;
      ch3_r    <= CH3_RST;
      ch4_r    <= CH4_RST;
      offset_r <= OFFSET_RST;
      sel_r    <= SEL_RST;
      fmt_r    <= FMT_RST;
    end
    else if (wr_go)
    begin
      // only bits 5-0 are stored, writes to 7-6 are dropped
      if (hit_ch2)
        ch2_r <= pwdata[5:0];
      if (hit_ch3)
        ch3_r <= pwdata[5:0];
      if (hit_ch4)
        ch4_r <= pwdata[5:0];
      if (hit_off)
        offset_r <= pwdata[4:0];
      if (hit_sel)
        sel_r <= pwdata[SEL_CH2 +: 3];
      if (hit_fmt)
        fmt_r <= pwdata[3:0];
    end
  end

  // configuration crossing; resent continuously so any change reaches bclk
  wire [CFG_W-1:0] cfg_src = {fmt_r, offset_r, sel_r,
                              ch4_r[EN_BIT], ch3_r[EN_BIT], ch2_r[EN_BIT],
                              ch4_r[SLOT_MSB:0], ch3_r[SLOT_MSB:0],
                              ch2_r[SLOT_MSB:0]};
  localparam logic [CFG_W-1:0] CFG_RST = {FMT_RST, OFFSET_RST, SEL_RST,
                                          3'h0, CH4_RST[4:0], CH3_RST[4:0],
                                          CH2_RST[4:0]};
  logic [CFG_W-1:0] cfg_b;

  word_xfer #(
    .W   (CFG_W),
    .RST (CFG_RST)
  ) u_cfg_xfer (
    .src_clk   (pclk),
    .src_rst_n (presetn),
    .send      (1'b1),
    .src_word  (cfg_src),
    .busy      (),
    .dst_clk   (bclk),
    .dst_rst_n (presetn),
    .dst_word  (cfg_b),
    .dst_valid ()
  );

  // configuration fields in the bclk domain
  // fmt_r[3:2] is word length, fmt_r[1:0] is format
  wire [1:0]  b_wl     = cfg_b[29:28];
  wire [1:0]  b_fmt    = cfg_b[27:26];
  wire [4:0]  b_offset = cfg_b[25:21];
  wire [2:0]  b_sel    = cfg_b[20:18];
  wire [2:0]  b_en     = cfg_b[17:15];
  wire [14:0] b_slots  = cfg_b[14:0];

  wire        is_tdm   = (b_fmt != FMT_I2S) && (b_fmt != FMT_LJ);
  wire        is_i2s   = b_fmt == FMT_I2S;
  wire [5:0]  wl       = wl_bits(b_wl);

  // frame framing, bclk domain
  logic        fs_prev_r;
  logic        running_r;
  logic        right_r;
  logic [5:0]  skip_r;
  logic [4:0]  bit_r;
  logic [4:0]  slot_r;

  wire         fs_rise  = fsync & ~fs_prev_r;
  wire         fs_fall  = ~fsync & fs_prev_r;
  // i2s and left-justified restart the slot count at each half
  wire         half_go  = is_tdm ? fs_rise : (fs_rise | fs_fall);
  wire         frame_go = is_i2s ? fs_fall : fs_rise;
  wire         right_now = is_i2s ? fsync : ~fsync;

  // programmable msb shift on top of the standard delay
  wire  [5:0]  std_dly  = is_i2s ? I2S_DELAY : STD_DELAY;
  wire  [5:0]  eff_skip = half_go ? (std_dly + {1'b0, b_offset}) : skip_r;
  wire         active   = half_go | running_r;
  wire         cap      = active && (eff_skip == 6'h00);
  wire  [4:0]  cur_bit  = half_go ? 5'h00 : bit_r;
  wire  [4:0]  cur_slot = half_go ? 5'h00 : slot_r;
  wire         cur_right = half_go ? right_now : right_r;
  wire         bit_last = {1'b0, cur_bit} == (wl - 6'h01);

  // slot number as the channel field names it
  wire         slot_ok  = is_tdm | ~cur_slot[4];
  wire  [4:0]  slot_num = is_tdm ? cur_slot : {cur_right, cur_slot[3:0]};

  always_ff @(posedge bclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fs_prev_r <= 1'b0;
      running_r <= 1'b0;
      right_r   <= 1'b0;
      skip_r    <= 6'h00;
      bit_r     <= 5'h00;
      slot_r    <= 5'h00;
    end
    else
    begin
      fs_prev_r <= fsync;
      if (half_go)
        right_r <= right_now;
      if (!active)
        running_r <= 1'b0;
      else if (!cap)
      begin
        running_r <= 1'b1;
        skip_r    <= eff_skip - 6'h01;
        bit_r     <= 5'h00;
        slot_r    <= 5'h00;
      end
      else if (bit_last)
      begin
        bit_r     <= 5'h00;
        slot_r    <= cur_slot + 5'h01;
        // counting stops after the last slot a half or frame can hold
        running_r <= is_tdm ? (cur_slot != 5'h1f) : (cur_slot != 5'h0f);
        skip_r    <= 6'h00;
      end
      else
      begin
        running_r <= 1'b1;
        skip_r    <= 6'h00;
        bit_r     <= cur_bit + 5'h01;
      end
    end
  end

  // per channel match and capture
  logic [31:0] cap_word [NUM_CH];
  logic [2:0]  cap_done;

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    // disabled channel never matches a slot
    wire hit = cap && slot_ok && b_en[c]
             && (slot_num == b_slots[5*c +: 5]);
    // primary pin when select is 0, second pin when 1
    wire dbit = b_sel[c] ? second_serial_input : din;

    chan_capture u_cap (
      .bclk     (bclk),
      .rst_n    (presetn),
      .clear    (frame_go),
      .hit      (hit),
      .bit_idx  (cur_bit),
      .last     (bit_last),
      .data_bit (dbit),
      .word     (cap_word[c]),
      .done     (cap_done[c])
    );
  end

  // a frame's words go across at the start of the next frame; if the
  // previous bundle is still in flight this frame is dropped
  wire [BUNDLE_W-1:0] bundle_src = {cap_done, cap_word[2], cap_word[1],
                                    cap_word[0]};
  wire                bundle_send = frame_go & (|cap_done);
  logic [BUNDLE_W-1:0] bundle_p;
  logic                bundle_v;

  word_xfer #(
    .W   (BUNDLE_W),
    .RST ('0)
  ) u_data_xfer (
    .src_clk   (bclk),
    .src_rst_n (presetn),
    .send      (bundle_send),
    .src_word  (bundle_src),
    .busy      (),
    .dst_clk   (pclk),
    .dst_rst_n (presetn),
    .dst_word  (bundle_p),
    .dst_valid (bundle_v)
  );

  // enable is checked again on pclk so a channel turned off stops at once
  wire [2:0] en_p   = {ch4_r[EN_BIT], ch3_r[EN_BIT], ch2_r[EN_BIT]};
  wire [2:0] deliver = {3{bundle_v}} & bundle_p[98:96] & en_p;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dac_data_ch2 <= 32'h0000_0000;
      dac_data_ch3 <= 32'h0000_0000;
      dac_data_ch4 <= 32'h0000_0000;
      dac_valid    <= 3'h0;
      frames_r     <= 8'h00;
    end
    else
    begin
      dac_valid <= deliver;
      if (deliver[0])
        dac_data_ch2 <= bundle_p[31:0];
      if (deliver[1])
        dac_data_ch3 <= bundle_p[63:32];
      if (deliver[2])
        dac_data_ch4 <= bundle_p[95:64];
      if (bundle_v)
        frames_r <= frames_r + 8'h01;
    end
  end

endmodule : rx_slot_map

/* include/rx_slot_pkg.sv */
// constants, field layout and types for the secondary serial receive slot map
// assumes a 32-bit apb slave and one-word-per-register addressing
package rx_slot_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_OFFSET = 8'h26;
  localparam logic [7:0]  IDX_SEL    = 8'h27;
  localparam logic [7:0]  IDX_CH2    = 8'h29;
  localparam logic [7:0]  IDX_CH3    = 8'h2a;
  localparam logic [7:0]  IDX_CH4    = 8'h2b;
  localparam logic [7:0]  IDX_FMT    = 8'h30;
  localparam logic [7:0]  IDX_STAT   = 8'h31;

  localparam int unsigned ADDR_W     = 12;
  localparam logic [11:0] ADDR_OFFSET = {2'h0, IDX_OFFSET, 2'h0};
  localparam logic [11:0] ADDR_SEL    = {2'h0, IDX_SEL, 2'h0};
  localparam logic [11:0] ADDR_CH2    = {2'h0, IDX_CH2, 2'h0};
  localparam logic [11:0] ADDR_CH3    = {2'h0, IDX_CH3, 2'h0};
  localparam logic [11:0] ADDR_CH4    = {2'h0, IDX_CH4, 2'h0};
  localparam logic [11:0] ADDR_FMT    = {2'h0, IDX_FMT, 2'h0};
  localparam logic [11:0] ADDR_STAT   = {2'h0, IDX_STAT, 2'h0};

  // channel register layout
  localparam int unsigned EN_BIT     = 5;
  localparam int unsigned SLOT_MSB   = 4;
  localparam int unsigned SEL_CH2    = 1;

  // values after reset
  localparam logic [5:0] CH2_RST    = 6'h01;
  localparam logic [5:0] CH3_RST    = 6'h02;
  localparam logic [5:0] CH4_RST    = 6'h03;
  localparam logic [4:0] OFFSET_RST = 5'h00;
  localparam logic [2:0] SEL_RST    = 3'h0;
  localparam logic [3:0] FMT_RST    = 4'h0;

  // standard msb delay after the frame edge
  localparam logic [5:0] I2S_DELAY  = 6'h01;
  localparam logic [5:0] STD_DELAY  = 6'h00;

  localparam int unsigned NUM_CH    = 3;
  localparam int unsigned CFG_W     = 30;
  localparam int unsigned BUNDLE_W  = 99;

  typedef enum logic [1:0] {FMT_TDM, FMT_I2S, FMT_LJ, FMT_RSVD} fmt_e;

  // word length code to bits per slot
  function automatic logic [5:0] wl_bits(input logic [1:0] code);
    logic [5:0] r;
    r = 6'h20;
    case (code)
      2'h0:    r = 6'h10;
      2'h1:    r = 6'h14;
      2'h2:    r = 6'h18;
      default: r = 6'h20;
    endcase
    return r;
  endfunction : wl_bits

endpackage : rx_slot_pkg

/* rtl/word_xfer.sv */
// toggle handshake carrying one word from one clock domain to another
// assumes the source holds send no longer than needed; busy blocks new words
`timescale 1ns/100ps
module word_xfer #(
  parameter int unsigned W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  // source side
  input  wire logic         src_clk,
  input  wire logic         src_rst_n,
  input  wire logic         send,
  input  wire logic [W-1:0] src_word,
  output wire logic         busy,
  // destination side
  input  wire logic         dst_clk,
  input  wire logic         dst_rst_n,
  output logic      [W-1:0] dst_word,
  output logic              dst_valid
);

  logic         req_r;
  logic         ack_s1_r;
  logic         ack_s2_r;
  logic [W-1:0] held_r;
  logic         req_s1_r;
  logic         req_s2_r;
  logic         req_s3_r;

  // held word is stable for the whole time the toggle is in flight
  assign busy = req_r ^ ack_s2_r;

  always_ff @(posedge src_clk or negedge src_rst_n)
  begin
    if (!src_rst_n)
    begin
      req_r    <= 1'b0;
      held_r   <= RST;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end
    else
    begin
      ack_s1_r <= req_s3_r;
      ack_s2_r <= ack_s1_r;
      if (send && !busy)
      begin
        held_r <= src_word;
        req_r  <= ~req_r;
      end
    end
  end

  always_ff @(posedge dst_clk or negedge dst_rst_n)
  begin
    if (!dst_rst_n)
    begin
      req_s1_r  <= 1'b0;
      req_s2_r  <= 1'b0;
      req_s3_r  <= 1'b0;
      dst_word  <= RST;
      dst_valid <= 1'b0;
    end
    else
    begin
      req_s1_r  <= req_r;
      req_s2_r  <= req_s1_r;
      req_s3_r  <= req_s2_r;
      dst_valid <= req_s2_r ^ req_s3_r;
      if (req_s2_r ^ req_s3_r)
        dst_word <= held_r;
    end
  end

endmodule : word_xfer

/* rtl/chan_capture.sv */
// gathers one channel's slot bits, msb first, left aligned in 32 bits
// runs on the link clock; hit marks a bit of this channel's slot
`timescale 1ns/100ps
module chan_capture (
  input  wire logic        bclk,
  input  wire logic        rst_n,
  // slot timing
  input  wire logic        clear,
  input  wire logic        hit,
  input  wire logic [4:0]  bit_idx,
  input  wire logic        last,
  input  wire logic        data_bit,
  // result
  output logic      [31:0] word,
  output logic             done
);

  logic [31:0] bit_mask;

  assign bit_mask = 32'h8000_0000 >> bit_idx;

  always_ff @(posedge bclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word <= 32'h0000_0000;
      done <= 1'b0;
    end
    else
    begin
      if (hit && bit_idx == 5'h00)
        word <= data_bit ? 32'h8000_0000 : 32'h0000_0000;
      else if (hit)
        word <= data_bit ? (word | bit_mask) : (word & ~bit_mask);
      if (hit && last)
        done <= 1'b1;
      else if (clear)
        done <= 1'b0;
    end
  end

endmodule : chan_capture

/* verification/rx_slot_map_checker.sv */
// checker for rx_slot_map: register readback and delivery gating
// assumes the bind below; shadows mirror the channel registers
`timescale 1ns/100ps
module rx_slot_map_checker
  import rx_slot_pkg::*;
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // dac side
  input wire logic [31:0] dac_data_ch2,
  input wire logic [2:0]  dac_valid
);
  logic [5:0] c2_r;
  logic [5:0] c3_r;
  logic [5:0] c4_r;
  wire        rd = psel && penable && pready && !pwrite;
  wire        wr = psel && penable && pready && pwrite;
  wire        h2 = paddr == ADDR_CH2;
  wire        h3 = paddr == ADDR_CH3;
  wire        h4 = paddr == ADDR_CH4;
  // shadows keep bits 5-0 only, so bits 7-6 must never come back
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      c2_r <= CH2_RST;
      c3_r <= CH3_RST;
      c4_r <= CH4_RST;
    end
    else if (wr)
    begin
      if (h2) c2_r <= pwdata[5:0];
      if (h3) c3_r <= pwdata[5:0];
      if (h4) c4_r <= pwdata[5:0];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_rd2; rd && h2 |-> prdata == {26'h0, c2_r}; endproperty
  a_rd2: assert property (p_rd2) else $error("ch2 readback wrong");
  property p_rd3; rd && h3 |-> prdata == {26'h0, c3_r}; endproperty
  a_rd3: assert property (p_rd3) else $error("ch3 readback wrong");
  property p_rd4; rd && h4 |-> prdata == {26'h0, c4_r}; endproperty
  a_rd4: assert property (p_rd4) else $error("ch4 readback wrong");
  property p_rsv; rd && (h2 || h3 || h4) |-> prdata[7:6] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("upper bits not zero");
  property p_en2; dac_valid[0] |-> c2_r[5]; endproperty
  a_en2: assert property (p_en2) else $error("ch2 delivered while off");
  property p_en3; dac_valid[1] |-> c3_r[5]; endproperty
  a_en3: assert property (p_en3) else $error("ch3 delivered while off");
  property p_en4; dac_valid[2] |-> c4_r[5]; endproperty
  a_en4: assert property (p_en4) else $error("ch4 delivered while off");
  property p_hold; $changed(dac_data_ch2) |-> ##[0:1] dac_valid[0]; endproperty
  a_hold: assert property (p_hold) else $error("ch2 word changed unannounced");
endmodule : rx_slot_map_checker
bind rx_slot_map rx_slot_map_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .dac_data_ch2, .dac_valid);

/* verification/frame_source.sv */
// host-side serial source: tdm, i2s or left justified frames of 128 bclk
// bclk runs on across the frames of a run and stands still between runs; data changes on falling bclk
`timescale 1ns/100ps
module frame_source (
  // serial link
  output logic bclk,
  output logic fsync,
  output logic din,
  output logic second_serial_input
);
  initial
  begin
    bclk = 1'b0;
    fsync = 1'b0;
    din = 1'b0;
    second_serial_input = 1'b1;
  end
  // word of stream slot s on pin p, distinct for every slot and pin
  function automatic logic [15:0] word(input int s, input logic p);
    return {4'ha, 3'(s) ^ 3'h5, p, ~p, 4'h9, 3'(s)};
  endfunction : word
  // n frames of eight 16-bit slots, msb first, d bclk after the frame edge
  task automatic run(input int n, input logic [1:0] fmt, input int d);
    int          i;
    logic [15:0] w0;
    logic [15:0] w1;
    #7;
    for (int f = 0; f < n; f++)
      for (int t = 0; t < 128; t++)
      begin
        i = (t + 128 - d) % 128;
        w0 = word(i / 16, 1'b0);
        w1 = word(i / 16, 1'b1);
        fsync = fmt == 2'h1 ? t >= 64 : fmt == 2'h2 ? t < 64 : t == 0;
        din = w0[15 - i % 16];
        second_serial_input = w1[15 - i % 16];
        #40 bclk = 1'b1;
        #40 bclk = 1'b0;
      end
    // released lines show the inverse of their last bit
    din = ~din;
    second_serial_input = ~second_serial_input;
  endtask : run
endmodule : frame_source

/* verification/testbench.sv */
// bench for rx_slot_map: apb register checks, then framed traffic
// from frame_source; every traffic case starts from a fresh reset
`timescale 1ns/100ps
module testbench
  import rx_slot_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        bclk;
  logic        fsync;
  logic        din;
  logic        second_serial_input;
  logic [31:0] dac [3];
  logic [2:0]  dac_valid;
  int          cnt [3];
  int          mismatches;
  int          checked;
  rx_slot_map i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bclk, .fsync, .din, .second_serial_input,
    .dac_data_ch2(dac[0]), .dac_data_ch3(dac[1]), .dac_data_ch4(dac[2]), .dac_valid);
  frame_source i_src (.bclk, .fsync, .din, .second_serial_input);
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // pulses last one cycle, so they are counted as they pass
  always @(posedge pclk)
    for (int k = 0; k < 3; k++)
      if (dac_valid[k] === 1'b1)
        cnt[k] <= cnt[k] + 1;
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic print_verdict;
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // request held until pready; reads are checked at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] x, input logic xe, input string nm);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      mismatches++;
      print_verdict();
    end
    if (!w)
    begin
      check(nm, x, prdata);
      check(nm, {31'h0, xe}, {31'h0, pslverr});
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0, "");
  endtask : wr
  task automatic reset(input int n);
    presetn <= 1'b0;
    repeat (n) @(posedge pclk);
    presetn <= 1'b1;
  endtask : reset
  // three frames: the second is delivered when the third starts
  task automatic traffic(input logic [1:0] fm, input logic [4:0] off, input logic [3:0] sel,
      input logic [5:0] c2, input logic [5:0] c3, input logic [5:0] c4);
    logic [5:0] c [3];
    int         b [3];
    int         v;
    c = '{c2, c3, c4};
    b = cnt;
    reset(3);
    wr(ADDR_FMT, {30'h0, fm});
    wr(ADDR_OFFSET, {27'h0, off});
    wr(ADDR_SEL, {28'h0, sel});
    wr(ADDR_CH2, {26'h0, c2});
    wr(ADDR_CH3, {26'h0, c3});
    wr(ADDR_CH4, {26'h0, c4});
    i_src.run(3, fm, int'(fm == 2'h1) + off);
    repeat (20) @(posedge pclk);
    for (int k = 0; k < 3; k++)
    begin
      v = c[k][4:0];
      // halves hold four slots, so right slot 0 is stream slot 4
      if ((fm == 2'h1 || fm == 2'h2) && v > 15)
        v = v - 12;
      check("delivered", {31'h0, c[k][5]}, {31'h0, cnt[k] != b[k]});
      if (c[k][5])
        check("dac word", {i_src.word(v, sel[k + 1]), 16'h0}, dac[k]);
    end
  endtask : traffic
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    @(posedge pclk);
    reset(12);
    apb(1'b0, ADDR_CH2, 32'h0, 32'h01, 1'b0, "ch2 reset");
    apb(1'b0, ADDR_CH3, 32'h0, 32'h02, 1'b0, "ch3 reset");
    apb(1'b0, ADDR_CH4, 32'h0, 32'h03, 1'b0, "ch4 reset");
    wr(ADDR_CH4, 32'h3f);
    apb(1'b0, ADDR_CH4, 32'h0, 32'h3f, 1'b0, "ch4 upper");
    apb(1'b0, 12'hffc, 32'h0, 32'h0, 1'b1, "unmapped");
    traffic(2'h0, 5'h00, 4'h0, 6'h21, 6'h02, 6'h23);
    traffic(2'h1, 5'h00, 4'h2, 6'h30, 6'h21, 6'h31);
    traffic(2'h2, 5'h01, 4'h8, 6'h20, 6'h30, 6'h03);
    traffic(2'h0, 5'h1f, 4'h4, 6'h00, 6'h22, 6'h21);
    print_verdict();
  end
endmodule : testbench
